/* File: verilog/nvb_ctrl.sv */
// Control of the 64-byte non-volatile store behind three registers
// Overview of operation
// - 64 bytes, one byte per access through index and value registers
// - Index register holds six bits; upper two bits read zero
// - Control register answers only at offset 40h in sector 01h
// - Reset clears all control bits, so nothing programs before enabling
// - Bit 3 is program permit; while zero, programming requests are refused
// - Bit 2 starts programming if permit set; hardware clears it at end
// - Bit 1 is fetch permit; while zero, read requests are refused
// - Bit 0 starts a read if permit set; hardware clears it at end
// - Read ends by loading value register; held until next operation
// - Programming is timed by a free-running timer, not clock counts
// - Programming end sets done flag and shared flag; request raised
// - Service clears only shared flag; software clears done flag
// - Done interrupt needs local enable and shared enable both set
// - Control bits 7 to 4 read zero, writes ignored
`timescale 1ns/10ps
`include "nvb_map.svh"
module nvb_ctrl #(
    parameter int DEPTH        = `NVB_DEPTH,
    parameter int FETCH_CYCLES = `NVB_FETCH_CYCLES,
    parameter int PROG_TICKS   = `NVB_PROG_TICKS
) (
    input  wire logic            CORE_CLK_I,
    input  wire logic            RESET_I,
    input  wire nvb_pkg::nvb_wr_t WR_I,
    input  wire logic [7:0]      PTR_LOW_I,
    input  wire logic [7:0]      PTR_HIGH_I,
    input  wire logic            PROG_TIMER_TICK_I,
    input  wire logic            DONE_IRQ_ENABLE_I,
    input  wire logic            SHARED_IRQ_ENABLE_I,
    input  wire logic            GLOBAL_IRQ_ENABLE_I,
    input  wire logic            STACK_FULL_I,
    input  wire logic            DONE_FLAG_CLEAR_I,
    input  wire logic            SHARED_FLAG_SERVICED_I,
    output nvb_pkg::nvb_rd_t     RD_O,
    output logic                 DONE_IRQ_FLAG_O,
    output logic                 SHARED_IRQ_FLAG_O,
    output logic                 IRQ_REQUEST_O,
    output logic                 BUSY_O
);
    import nvb_pkg::*;

    localparam int AW = `NVB_INDEX_BITS;

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [AW-1:0] nv_byte_index;
    logic [7:0]    nv_byte_value;
    logic          program_permit;
    logic          prog_go;
    logic          fetch_permit;
    logic          fetch_go;
    nvb_state_t    state;
    nvb_state_t    next_state;
    logic [3:0]    fetch_cnt;
    logic [7:0]    tick_cnt;
    logic [AW-1:0] cap_index;
    logic [7:0]    cap_value;
    logic          done_flag;
    logic          shared_flag;
    logic [7:0]    store_rdata;

    // ------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------
    // control offset check
    // Only the indirect pointer pair selects the control register
    wire ctrl_sel   = (PTR_LOW_I == `NVB_CTRL_OFFSET) && (PTR_HIGH_I == `NVB_CTRL_SECTOR);
    wire ctrl_write = WR_I.ctrl_we && ctrl_sel;
    wire idle       = (state == NVB_IDLE);
    // program permit gate
    // Permit must already be one; the same write cannot enable itself
    wire prog_start = ctrl_write && WR_I.wdata[`NVB_BIT_PROG_GO] && program_permit && idle;
    wire fetch_start = ctrl_write && WR_I.wdata[`NVB_BIT_FETCH_GO] && fetch_permit && idle
                       && !prog_start;
    wire fetch_end  = (state == NVB_FETCH) && (fetch_cnt == 4'(FETCH_CYCLES - 1));
    // asynchronous timer ticks
    // Tick arrives already synchronous; its rate is unrelated to the core clock
    wire prog_end   = (state == NVB_PROG) && PROG_TIMER_TICK_I
                      && (tick_cnt == 8'(PROG_TICKS - 1));
    wire store_we   = prog_end;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        unique case (state)
            NVB_IDLE:
            begin
                if (prog_start)
                    next_state = NVB_PROG;
                else if (fetch_start)
                    next_state = NVB_FETCH;
            end
            NVB_FETCH:
            begin
                if (fetch_end)
                    next_state = NVB_IDLE;
            end
            NVB_PROG:
            begin
                if (prog_end)
                    next_state = NVB_IDLE;
            end
            default: next_state = NVB_IDLE;
        endcase
    end

    // reset clears control
    // State, fetch cycle counter and programming timer tick counter
    always_ff @(posedge CORE_CLK_I)
    begin
        if (RESET_I)
        begin
            state     <= NVB_IDLE;
            fetch_cnt <= 4'h0;
            tick_cnt  <= 8'h00;
        end
        else
        begin
            state     <= next_state;
            fetch_cnt <= (state == NVB_FETCH) ? fetch_cnt + 4'h1 : 4'h0;
            if (state != NVB_PROG)
                tick_cnt <= 8'h00;
            else if (PROG_TIMER_TICK_I)
                tick_cnt <= tick_cnt + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    // upper bits not stored
    // Permits follow software; go bits set on accepted start, cleared at end
    always_ff @(posedge CORE_CLK_I)
    begin
        if (RESET_I)
        begin
            program_permit <= 1'b0;
            fetch_permit   <= 1'b0;
            prog_go        <= 1'b0;
            fetch_go       <= 1'b0;
        end
        else
        begin
            if (ctrl_write)
            begin
                program_permit <= WR_I.wdata[`NVB_BIT_PROG_PERMIT];
                fetch_permit   <= WR_I.wdata[`NVB_BIT_FETCH_PERMIT];
            end
            if (prog_start)
                prog_go <= 1'b1;
            else if (prog_end)
                prog_go <= 1'b0;
            if (fetch_start)
                fetch_go <= 1'b1;
            else if (fetch_end)
                fetch_go <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Index and value registers
    // ------------------------------------------------------------
    // six-bit index
    // value loaded at read end
    // The read end wins over a software value write in the same cycle
    always_ff @(posedge CORE_CLK_I)
    begin
        if (RESET_I)
        begin
            nv_byte_index <= AW'(`NVB_INDEX_RESET);
            nv_byte_value <= `NVB_VALUE_RESET;
        end
        else
        begin
            if (WR_I.index_we)
                nv_byte_index <= WR_I.wdata[AW-1:0];
            if (fetch_end)
                nv_byte_value <= store_rdata;
            else if (WR_I.value_we)
                nv_byte_value <= WR_I.wdata;
        end
    end

    always_ff @(posedge CORE_CLK_I)
    begin
        if (RESET_I)
        begin
            cap_index <= '0;
            cap_value <= 8'h00;
        end
        else if (prog_start)
        begin
            cap_index <= nv_byte_index;
            cap_value <= nv_byte_value;
        end
    end

    // ------------------------------------------------------------
    // Done flags
    // ------------------------------------------------------------
    // flags set at end
    // separate clears
    // Set wins over a clear in the same cycle
    always_ff @(posedge CORE_CLK_I)
    begin
        if (RESET_I)
        begin
            done_flag   <= 1'b0;
            shared_flag <= 1'b0;
        end
        else
        begin
            done_flag   <= prog_end | (done_flag & ~DONE_FLAG_CLEAR_I);
            shared_flag <= prog_end | (shared_flag & ~SHARED_FLAG_SERVICED_I);
        end
    end

    // ------------------------------------------------------------
    // Storage and outputs
    // ------------------------------------------------------------
    // byte array
    nvb_store #(
        .DEPTH   (DEPTH),
        .AW      (AW)
    ) u_store (
        .clk_i   (CORE_CLK_I),
        .we_i    (store_we),
        .addr_i  (store_we ? cap_index : nv_byte_index),
        .wdata_i (cap_value),
        .rdata_o (store_rdata)
    );

    // One driver for the whole read-back word; unused bits tied low
    assign RD_O = '{index: {2'b00, nv_byte_index},
                    value: nv_byte_value,
                    ctrl:  {4'h0, program_permit, prog_go, fetch_permit, fetch_go}};
    assign DONE_IRQ_FLAG_O   = done_flag;
    assign SHARED_IRQ_FLAG_O = shared_flag;
    assign IRQ_REQUEST_O = done_flag && shared_flag && DONE_IRQ_ENABLE_I
                           && SHARED_IRQ_ENABLE_I && GLOBAL_IRQ_ENABLE_I && !STACK_FULL_I;
    assign BUSY_O = !idle;
endmodule : nvb_ctrl

/* File: verilog/nvb_map.svh */
// Offsets, field positions, reset values and timing counts of the byte store
`ifndef NVB_MAP_SVH
`define NVB_MAP_SVH
`define NVB_CTRL_OFFSET      8'h40
`define NVB_CTRL_SECTOR      8'h01
`define NVB_CTRL_RESET       8'h00
`define NVB_INDEX_RESET      8'h00
`define NVB_VALUE_RESET      8'h00
`define NVB_BIT_FETCH_GO     0
`define NVB_BIT_FETCH_PERMIT 1
`define NVB_BIT_PROG_GO      2
`define NVB_BIT_PROG_PERMIT  3
`define NVB_DEPTH            64
`define NVB_INDEX_BITS       6
`define NVB_FETCH_CYCLES     4'h2
`define NVB_PROG_TICKS       8'h10
`endif

/* File: verilog/nvb_pkg.sv */
// Types shared by the non-volatile byte store control
package nvb_pkg;
    // Register write strobes from the core, with the byte written
    typedef struct packed {
        logic       index_we;
        logic       value_we;
        logic       ctrl_we;
        logic [7:0] wdata;
    } nvb_wr_t;

    // Read-back of the three registers
    typedef struct packed {
        logic [7:0] index;
        logic [7:0] value;
        logic [7:0] ctrl;
    } nvb_rd_t;

    typedef enum logic [1:0] {
        NVB_IDLE  = 2'b00,
        NVB_FETCH = 2'b01,
        NVB_PROG  = 2'b10
    } nvb_state_t;
endpackage : nvb_pkg

/* File: verilog/nvb_store.sv */
// Byte array of the non-volatile store with registered read data
`timescale 1ns/10ps
module nvb_store #(
    parameter int DEPTH = 64,
    parameter int AW    = 6
) (
    input  wire logic          clk_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] addr_i,
    input  wire logic [7:0]    wdata_i,
    output logic      [7:0]    rdata_o
);
    logic [7:0] mem [DEPTH];

    // Array keeps content over reset, as non-volatile cells do
    always_ff @(posedge clk_i)
    begin
        if (we_i)
            mem[addr_i] <= wdata_i;
        rdata_o <= mem[addr_i];
    end
endmodule : nvb_store

/* File: tb/nvb_ctrl_props.sv */
// Concurrent checks on the byte store control ports
`timescale 1ns/10ps
module nvb_ctrl_props (
    input wire logic             CORE_CLK_I,
    input wire logic             RESET_I,
    input wire nvb_pkg::nvb_wr_t WR_I,
    input wire logic [7:0]       PTR_LOW_I,
    input wire logic [7:0]       PTR_HIGH_I,
    input wire logic             DONE_IRQ_ENABLE_I,
    input wire logic             SHARED_IRQ_ENABLE_I,
    input wire logic             GLOBAL_IRQ_ENABLE_I,
    input wire logic             STACK_FULL_I,
    input wire logic             DONE_FLAG_CLEAR_I,
    input wire logic             SHARED_FLAG_SERVICED_I,
    input wire nvb_pkg::nvb_rd_t RD_O,
    input wire logic             DONE_IRQ_FLAG_O,
    input wire logic             SHARED_IRQ_FLAG_O,
    input wire logic             IRQ_REQUEST_O,
    input wire logic             BUSY_O
);
    import nvb_pkg::*;
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (RESET_I);
    // Control write that reaches the register while idle
    wire ptr_ok = PTR_LOW_I == 8'h40 && PTR_HIGH_I == 8'h01;
    wire ctl_wr = WR_I.ctrl_we && ptr_ok && !BUSY_O;
    wire all_en = DONE_IRQ_ENABLE_I && SHARED_IRQ_ENABLE_I && GLOBAL_IRQ_ENABLE_I;
    // ----------------------------------------
    // Port checks
    // ----------------------------------------
    chk_upper_zero: assert property (RD_O.index[7:6] == 2'h0 && RD_O.ctrl[7:4] == 4'h0)
        else $error("unimplemented bits read nonzero");
    chk_ptr_guard: assert property (WR_I.ctrl_we && !ptr_ok && !BUSY_O |=> $stable(RD_O.ctrl))
        else $error("control changed through wrong pointer");
    chk_prog_refused: assert property (ctl_wr && WR_I.wdata[2] && !RD_O.ctrl[3] |=> !RD_O.ctrl[2])
        else $error("programming started without permit");
    chk_fetch_refused: assert property (ctl_wr && WR_I.wdata[0] && !RD_O.ctrl[1] |=> !RD_O.ctrl[0])
        else $error("read started without permit");
    chk_fetch_time: assert property (ctl_wr && WR_I.wdata[1:0] == 2'h3 && !WR_I.wdata[2] && RD_O.ctrl[1]
        |=> RD_O.ctrl[0] ##[1:2] !RD_O.ctrl[0])
        else $error("read cycle length wrong");
    chk_value_hold: assert property (!BUSY_O && !WR_I.value_we |=> $stable(RD_O.value))
        else $error("value register changed while idle");
    chk_done_flags: assert property ($fell(RD_O.ctrl[2]) |-> ##[0:1] (DONE_IRQ_FLAG_O && SHARED_IRQ_FLAG_O))
        else $error("flags not set at programming end");
    chk_irq_gate: assert property (IRQ_REQUEST_O |-> all_en && !STACK_FULL_I)
        else $error("request raised while masked");
    chk_irq_raise: assert property (DONE_IRQ_FLAG_O && SHARED_IRQ_FLAG_O && all_en && !STACK_FULL_I
        |-> IRQ_REQUEST_O)
        else $error("request missing");
    chk_service_one: assert property (SHARED_FLAG_SERVICED_I && !DONE_FLAG_CLEAR_I && !BUSY_O
        |=> !SHARED_IRQ_FLAG_O && $stable(DONE_IRQ_FLAG_O))
        else $error("service cleared the wrong flag");
endmodule : nvb_ctrl_props
bind nvb_ctrl nvb_ctrl_props u_nvb_ctrl_props (.CORE_CLK_I, .RESET_I, .WR_I, .PTR_LOW_I,
    .PTR_HIGH_I, .DONE_IRQ_ENABLE_I, .SHARED_IRQ_ENABLE_I, .GLOBAL_IRQ_ENABLE_I,
    .STACK_FULL_I, .DONE_FLAG_CLEAR_I, .SHARED_FLAG_SERVICED_I, .RD_O, .DONE_IRQ_FLAG_O,
    .SHARED_IRQ_FLAG_O, .IRQ_REQUEST_O, .BUSY_O);

/* File: tb/tb_nvb_ctrl.sv */
// Self-checking bench for the byte store control
`timescale 1ns/10ps
module tb_nvb_ctrl;
    import nvb_pkg::*;
    logic core_clk, reset, tick, done_clr, serviced, stack_full, done_flag, shared_flag, irq, busy;
    logic       done_en, shared_en, glob;
    logic [7:0] ptr_low, ptr_high;
    nvb_wr_t    wr;
    nvb_rd_t    rd;
    int         n_errors, tests_run, n;
    // Rows: kind, pointer high:low swapped as {low,high}, data, expected {index,value,ctrl}
    localparam logic [49:0] ROWS [7] = '{{2'h0, 16'h4001, 8'hff, 24'h3f0000},
        {2'h1, 16'h4001, 8'ha5, 24'h3fa500}, {2'h2, 16'h4001, 8'hf2, 24'h3fa502},
        {2'h2, 16'h4000, 8'h08, 24'h3fa502}, {2'h2, 16'h4101, 8'h00, 24'h3fa502},
        {2'h2, 16'h4001, 8'h04, 24'h3fa500}, {2'h2, 16'h4001, 8'h01, 24'h3fa500}};
    nvb_ctrl #(.PROG_TICKS(2)) u_nvb_ctrl (.CORE_CLK_I(core_clk), .RESET_I(reset), .WR_I(wr),
        .PTR_LOW_I(ptr_low), .PTR_HIGH_I(ptr_high), .PROG_TIMER_TICK_I(tick),
        .DONE_IRQ_ENABLE_I(done_en), .SHARED_IRQ_ENABLE_I(shared_en), .GLOBAL_IRQ_ENABLE_I(glob),
        .STACK_FULL_I(stack_full), .DONE_FLAG_CLEAR_I(done_clr),
        .SHARED_FLAG_SERVICED_I(serviced), .RD_O(rd), .DONE_IRQ_FLAG_O(done_flag),
        .SHARED_IRQ_FLAG_O(shared_flag), .IRQ_REQUEST_O(irq), .BUSY_O(busy));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    // Comparison with four-state equality
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // One register write, strobe held over a single rising edge
    task automatic wr_reg(input logic [1:0] k, input logic [7:0] d);
        @(negedge core_clk);
        wr = '{index_we: k == 2'h0, value_we: k == 2'h1, ctrl_we: k == 2'h2, wdata: d};
        @(negedge core_clk);
        wr = '0;
    endtask : wr_reg
    // One-cycle pulse on a strobe input
    task automatic pulse(ref logic s);
        @(negedge core_clk);
        s = 1'b1;
        @(negedge core_clk);
        s = 1'b0;
    endtask : pulse
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict
    // ----------------------------------------
    // Clock, watchdog and tests
    // ----------------------------------------
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // Whole run is under a hundred cycles; far longer means a hang
    initial
    begin
        #16000;
        n_errors++;
        print_verdict();
    end
    initial
    begin
        {tick, done_clr, serviced, stack_full} = 4'h0;
        {done_en, shared_en, glob} = 3'h7;
        n_errors = 0;
        tests_run = 0;
        reset = 1'b1;
        wr = '0;
        {ptr_low, ptr_high} = 16'h4001;
        // Four rising edges under reset, released off the edge
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        reset = 1'b0;
        for (int i = 0; i < 7; i++)
        begin
            {ptr_low, ptr_high} = ROWS[i][47:32];
            wr_reg(ROWS[i][49:48], ROWS[i][31:24]);
            check(rd, ROWS[i][23:0]);
        end
        $display("register rows done");
        wr_reg(2'h0, 8'h2a);
        wr_reg(2'h1, 8'h5c);
        glob = 1'b0;
        wr_reg(2'h2, 8'h08);
        wr_reg(2'h2, 8'h0c);
        glob = 1'b1;
        // Index and value changed while busy must not reach the array
        wr_reg(2'h1, 8'h11);
        wr_reg(2'h0, 8'h00);
        check(24'({busy, rd.ctrl}), 24'h10c);
        pulse(tick);
        pulse(tick);
        check(24'(rd.ctrl), 24'h08);
        @(negedge core_clk);
        check(24'({done_flag, shared_flag, irq}), 24'h7);
        // Either local enable alone must not raise the request
        {done_en, shared_en} = 2'h1;
        @(negedge core_clk);
        check(24'(irq), 24'h0);
        {done_en, shared_en} = 2'h2;
        @(negedge core_clk);
        check(24'(irq), 24'h0);
        {done_en, shared_en} = 2'h3;
        stack_full = 1'b1;
        @(negedge core_clk);
        check(24'(irq), 24'h0);
        pulse(serviced);
        check(24'({done_flag, shared_flag}), 24'h2);
        pulse(done_clr);
        check(24'(done_flag), 24'h0);
        $display("programming done");
        // Read back the programmed byte
        wr_reg(2'h0, 8'h2a);
        wr_reg(2'h2, 8'h02);
        wr_reg(2'h2, 8'h03);
        n = 0;
        while (rd.ctrl[0] === 1'b1 && n < 8)
        begin
            @(negedge core_clk);
            n++;
        end
        check(24'(n), 24'h2);
        check(rd, 24'h2a5c02);
        wr_reg(2'h0, 8'h3f);
        repeat (3) @(negedge core_clk);
        check(24'(rd.value), 24'h5c);
        $display("read done");
        // Reset in mid-run clears registers and flags; the array keeps its content
        wr_reg(2'h2, 8'h08);
        reset = 1'b1;
        @(negedge core_clk);
        reset = 1'b0;
        check(rd, 24'h0);
        check(24'({done_flag, shared_flag}), 24'h0);
        // Go right after reset is refused because the permit was cleared
        wr_reg(2'h2, 8'h04);
        check(24'({busy, rd.ctrl}), 24'h0);
        $display("reset done");
        print_verdict();
    end
endmodule : tb_nvb_ctrl
